//--- verilog/dcca_top.sv
/*
  Two capture/compare units, each with sixteen channels and two timers,
  behind a plain register port with read data one cycle after the strobe.
  Assumes channel pins and external count inputs are asynchronous, the
  concatenation overflow pulse comes from logic on clk, and the far side
  resolves each pin from cc_pin_out and the active-low cc_pin_oe_n.
*/
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - two units of sixteen channels each, thirty-two channels in all
// - each unit has two 16-bit timers, each with its own reload register
// - timers count prescaled clock ticks or concatenation timer overflows
// - 3-bit select code picks dividers 8 up to 1024 in powers of two
// - one timer count per prescaler-factor clock cycles
// - first timer of each unit can also count external input rising edges
// - each channel picks either unit timer and capture or compare use
// - each channel owns one pin; unit 2 channels 8 to 11 are input only
// - capture latches the allocated timer value on the selected pin edge
// - every capture raises that channel's interrupt request
// - capture edge is rising, falling, or both
// - compare channels match against their timer; action follows the mode
// - compare mode 0 interrupts on every match and leaves the pin alone
// - compare mode 1 toggles the pin on every match
// - compare mode 2 interrupts on the first match of each period only
// - compare mode 3 sets pin on match, clears it on timer overflow
// - double mode lets two channels toggle one shared pin
// - period depends on reload value, longest with reload zero
module dcca_top import dcca_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic [NUM_CH-1:0] cc_pin_in,
  output logic      [NUM_CH-1:0] cc_pin_out,
  output logic      [NUM_CH-1:0] cc_pin_oe_n,
  input  wire logic [NUM_UNITS-1:0] ext_count_in,
  input  wire logic              concat_ovf,
  output logic      [NUM_CH-1:0] cc_irq,
  output logic      [NUM_TMR-1:0] timer_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [5:0]          ch_mode_r [NUM_CH];
  logic [5:0]          tctl_r    [NUM_TMR];
  logic [TMR_W-1:0]    trel_r    [NUM_TMR];
  logic [FLAG_W-1:0]   flag_r    [NUM_UNITS];
  logic [FLAG_W-1:0]   flag_nxt  [NUM_UNITS];
  logic [FLAG_W-1:0]   ien_r     [NUM_UNITS];
  logic [NUM_CH-1:0]   pin_s1_r;
  logic [NUM_CH-1:0]   pin_s2_r;
  logic [NUM_UNITS-1:0] ext_s1_r;
  logic [NUM_UNITS-1:0] ext_s2_r;
  logic [NUM_UNITS-1:0] ext_d_r;
  logic [DATA_W-1:0]   rdata_nxt;

  // timer and channel wires
  logic [TMR_W-1:0]    tmr_cnt [NUM_TMR];
  logic [NUM_TMR-1:0]  tmr_ovf;
  logic [NUM_TMR-1:0]  tmr_upd;
  logic [NUM_TMR-1:0]  tmr_wr;
  logic [TMR_W-1:0]    ch_val  [NUM_CH];
  logic [NUM_CH-1:0]   ch_hit;
  logic [NUM_CH-1:0]   ch_evt;
  logic [NUM_CH-1:0]   ch_pin;
  logic [NUM_CH-1:0]   ch_drive;
  logic [NUM_CH-1:0]   ch_wr;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic       acc_unit;
  logic [5:0] acc_ofs;
  logic       ofs_ch_val;
  logic       ofs_ch_mode;
  logic [3:0] acc_ch;
  logic       ofs_flags;
  logic       ofs_ien;

  // true when the offset lands in a sixteen-entry channel block
  function automatic logic dcca_in_block(input logic [5:0] ofs, input logic [5:0] base);
    dcca_in_block = (ofs[5:4] == base[5:4]);
  endfunction : dcca_in_block

  // word address of a per-timer register of timer t in its unit
  function automatic logic dcca_is_tmr_reg(input logic [5:0] ofs, input logic [5:0] base, input int j);
    dcca_is_tmr_reg = (ofs == 6'(base + 6'(j)));
  endfunction : dcca_is_tmr_reg

  assign acc_unit    = reg_addr[UNIT_BIT];
  assign acc_ofs     = reg_addr[5:0];
  assign acc_ch      = acc_ofs[3:0];
  assign ofs_ch_val  = dcca_in_block(acc_ofs, OFS_CH_VAL);
  assign ofs_ch_mode = dcca_in_block(acc_ofs, OFS_CH_MODE);
  assign ofs_flags   = (acc_ofs == OFS_FLAGS);
  assign ofs_ien     = (acc_ofs == OFS_IEN);

  // ----------------------------------------------------------------
  // pin and external input synchronisers
  // ----------------------------------------------------------------
  // only the second stage is read; ext_d_r gives the edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_d_r  <= '0;
    end else begin
      pin_s1_r <= cc_pin_in;
      pin_s2_r <= pin_s1_r;
      ext_s1_r <= ext_count_in;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // timers, two per unit
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < NUM_TMR; t++) begin : g_tmr
      localparam int U = t / TMR_PER_UNIT;
      localparam int J = t % TMR_PER_UNIT;
      assign tmr_wr[t] = reg_wr & (acc_unit == U[0]) & dcca_is_tmr_reg(acc_ofs, OFS_TCNT0, J);

      dcca_timer #(
        .EXT_OK     (J == 0)
      ) u_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .run        (tctl_r[t][TCTL_RUN_BIT]),
        .src        (tctl_r[t][TCTL_SRC_LSB +: 2]),
        .sel        (tctl_r[t][TCTL_SEL_LSB +: 3]),
        .ext_rise   (ext_s2_r[U] & ~ext_d_r[U]),
        .concat_ovf (concat_ovf),
        .wr         (tmr_wr[t]),
        .wdata      (reg_wdata[TMR_W-1:0]),
        .reload     (trel_r[t]),
        .cnt        (tmr_cnt[t]),
        .ovf        (tmr_ovf[t]),
        .upd        (tmr_upd[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // channels, sixteen per unit
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam int U = c / CH_PER_UNIT;
      localparam int K = c % CH_PER_UNIT;
      // partner for the shared pin sits eight channels away in its unit
      localparam int P = U * CH_PER_UNIT + (K ^ 8);
      logic [1:0] tsel;

      assign tsel     = {1'b0, ch_mode_r[c][TSEL_BIT]};
      assign ch_wr[c] = reg_wr & (acc_unit == U[0]) & ofs_ch_val & (acc_ch == K[3:0]);

      dcca_channel #(
        .OUT_OK      (!INPUT_ONLY_MASK[c])
      ) u_channel (
        .clk         (clk),
        .reset_n     (reset_n),
        .mode        (ch_mode_r[c][MODE_LSB +: 3]),
        .edge_sel    (ch_mode_r[c][EDGE_LSB +: 2]),
        .pin_lvl     (pin_s2_r[c]),
        .tmr_cnt     (tmr_cnt[U*TMR_PER_UNIT + int'(tsel)]),
        .tmr_upd     (tmr_upd[U*TMR_PER_UNIT + int'(tsel)]),
        .tmr_ovf     (tmr_ovf[U*TMR_PER_UNIT + int'(tsel)]),
        .partner_hit (ch_hit[P]),
        .wr          (ch_wr[c]),
        .wdata       (reg_wdata[TMR_W-1:0]),
        .val         (ch_val[c]),
        .hit         (ch_hit[c]),
        .evt         (ch_evt[c]),
        .pin_q       (ch_pin[c]),
        .drive       (ch_drive[c])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // request flags: set wins over a write-one-to-clear
  // ----------------------------------------------------------------
  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_flag
      logic [FLAG_W-1:0] set_v;
      logic [FLAG_W-1:0] clr_v;
      assign set_v = {tmr_ovf[u*TMR_PER_UNIT +: TMR_PER_UNIT], ch_evt[u*CH_PER_UNIT +: CH_PER_UNIT]};
      assign clr_v = (reg_wr & (acc_unit == 1'(u)) & ofs_flags) ? reg_wdata[FLAG_W-1:0] : '0;
      assign flag_nxt[u] = (flag_r[u] & ~clr_v) | set_v;
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_mode_r[i] <= RST_MODE;
      end
      for (int i = 0; i < NUM_TMR; i++) begin
        tctl_r[i] <= RST_TCTL;
        trel_r[i] <= RST_RELOAD;
      end
    end else if (reg_wr) begin
      if (ofs_ch_mode) begin
        ch_mode_r[{acc_unit, acc_ch}] <= reg_wdata[5:0];
      end
      for (int j = 0; j < TMR_PER_UNIT; j++) begin
        if (dcca_is_tmr_reg(acc_ofs, OFS_TREL0, j)) begin
          trel_r[{acc_unit, j[0]}] <= reg_wdata[TMR_W-1:0];
        end
        if (dcca_is_tmr_reg(acc_ofs, OFS_TCTL0, j)) begin
          tctl_r[{acc_unit, j[0]}] <= reg_wdata[5:0];
        end
      end
    end
  end

  // flags, enables and interrupt request outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        flag_r[i] <= RST_FLAGS;
        ien_r[i]  <= RST_FLAGS;
      end
      cc_irq    <= '0;
      timer_irq <= '0;
    end else begin
      for (int i = 0; i < NUM_UNITS; i++) begin
        flag_r[i] <= flag_nxt[i];
        if (reg_wr && ofs_ien && (acc_unit == i[0])) begin
          ien_r[i] <= reg_wdata[FLAG_W-1:0];
        end
        cc_irq[i*CH_PER_UNIT +: CH_PER_UNIT]     <= flag_r[i][CH_PER_UNIT-1:0] & ien_r[i][CH_PER_UNIT-1:0];
        timer_irq[i*TMR_PER_UNIT +: TMR_PER_UNIT] <= flag_r[i][FLAG_W-1:CH_PER_UNIT] &
                                                     ien_r[i][FLAG_W-1:CH_PER_UNIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins: registered level and active-low enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cc_pin_out  <= '0;
      cc_pin_oe_n <= '1;
    end else begin
      cc_pin_out  <= ch_pin & ch_drive;
      cc_pin_oe_n <= ~ch_drive;
    end
  end

  // ----------------------------------------------------------------
  // read path; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (ofs_ch_val) begin
      rdata_nxt[TMR_W-1:0] = ch_val[{acc_unit, acc_ch}];
    end else if (ofs_ch_mode) begin
      rdata_nxt[5:0] = ch_mode_r[{acc_unit, acc_ch}];
    end else begin
      case (acc_ofs)
        OFS_TCNT0: rdata_nxt[TMR_W-1:0]  = tmr_cnt[{acc_unit, 1'b0}];
        OFS_TCNT1: rdata_nxt[TMR_W-1:0]  = tmr_cnt[{acc_unit, 1'b1}];
        OFS_TREL0: rdata_nxt[TMR_W-1:0]  = trel_r[{acc_unit, 1'b0}];
        OFS_TREL1: rdata_nxt[TMR_W-1:0]  = trel_r[{acc_unit, 1'b1}];
        OFS_TCTL0: rdata_nxt[5:0]        = tctl_r[{acc_unit, 1'b0}];
        OFS_TCTL1: rdata_nxt[5:0]        = tctl_r[{acc_unit, 1'b1}];
        OFS_FLAGS: rdata_nxt[FLAG_W-1:0] = flag_r[acc_unit];
        OFS_IEN:   rdata_nxt[FLAG_W-1:0] = ien_r[acc_unit];
        default:   rdata_nxt             = '0;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : '0;
    end
  end
endmodule : dcca_top
`default_nettype wire

//--- verilog/dcca_pkg.sv
/*
  Constants, modes, register offsets and field positions shared by the
  dual capture/compare array and its timer and channel leaves.
  Assumes a single 200 MHz clock and word-indexed register offsets.
*/
`default_nettype none
package dcca_pkg;
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int NUM_UNITS    = 2;
  localparam int CH_PER_UNIT  = 16;
  localparam int TMR_PER_UNIT = 2;
  localparam int NUM_CH       = NUM_UNITS * CH_PER_UNIT;
  localparam int NUM_TMR      = NUM_UNITS * TMR_PER_UNIT;
  localparam int TMR_W        = 16;
  localparam int ADDR_W       = 7;
  localparam int DATA_W       = 32;
  localparam int FLAG_W       = CH_PER_UNIT + TMR_PER_UNIT;
  localparam int CPU_CLK_MHZ  = 200;
  // channels that own an input-only pin (unit 2, channels 8 to 11)
  localparam logic [NUM_CH-1:0] INPUT_ONLY_MASK = 32'h0f00_0000;

  // ----------------------------------------------------------------
  // register offsets inside one unit, unit select is address bit 6
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CH_VAL  = 6'h00;
  localparam logic [5:0] OFS_CH_MODE = 6'h10;
  localparam logic [5:0] OFS_TCNT0   = 6'h20;
  localparam logic [5:0] OFS_TCNT1   = 6'h21;
  localparam logic [5:0] OFS_TREL0   = 6'h22;
  localparam logic [5:0] OFS_TREL1   = 6'h23;
  localparam logic [5:0] OFS_TCTL0   = 6'h24;
  localparam logic [5:0] OFS_TCTL1   = 6'h25;
  localparam logic [5:0] OFS_FLAGS   = 6'h26;
  localparam logic [5:0] OFS_IEN     = 6'h27;
  localparam int         UNIT_BIT    = 6;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int TCTL_SEL_LSB = 0;
  localparam int TCTL_SRC_LSB = 3;
  localparam int TCTL_RUN_BIT = 5;
  localparam int MODE_LSB     = 0;
  localparam int EDGE_LSB     = 3;
  localparam int TSEL_BIT     = 5;
  localparam logic [5:0]        RST_TCTL   = 6'h00;
  localparam logic [5:0]        RST_MODE   = 6'h00;
  localparam logic [TMR_W-1:0]  RST_RELOAD = 16'h0000;
  localparam logic [FLAG_W-1:0] RST_FLAGS  = 18'h00000;

  // ----------------------------------------------------------------
  // prescaler: divider is 8 shifted left by the 3-bit select code
  // ----------------------------------------------------------------
  localparam int PRESC_BASE_LOG2 = 3;
  localparam int PRESC_W         = 10;

  typedef enum logic [2:0] {
    DCCA_OFF     = 3'h0,
    DCCA_CAPTURE = 3'h1,
    DCCA_CMP0    = 3'h2,
    DCCA_CMP1    = 3'h3,
    DCCA_CMP2    = 3'h4,
    DCCA_CMP3    = 3'h5,
    DCCA_DOUBLE  = 3'h6
  } dcca_mode_t;

  typedef enum logic [1:0] {
    DCCA_SRC_PRESC  = 2'h0,
    DCCA_SRC_CONCAT = 2'h1,
    DCCA_SRC_EXT    = 2'h2
  } dcca_src_t;

  // last prescaler count before a tick, factor minus one
  function automatic logic [PRESC_W-1:0] dcca_presc_last(input logic [2:0] sel);
    dcca_presc_last = PRESC_W'((11'h001 << (PRESC_BASE_LOG2 + int'(sel))) - 11'h001);
  endfunction : dcca_presc_last
endpackage : dcca_pkg
`default_nettype wire

//--- verilog/dcca_timer.sv
/*
  One 16-bit up-counting time base with reload and prescaler.
  Assumes the external count rise and concatenation overflow inputs are
  single-cycle pulses already in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcca_timer import dcca_pkg::*; #(
  parameter bit EXT_OK = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             run,
  input  wire logic [1:0]       src,
  input  wire logic [2:0]       sel,
  input  wire logic             ext_rise,
  input  wire logic             concat_ovf,
  input  wire logic             wr,
  input  wire logic [TMR_W-1:0] wdata,
  input  wire logic [TMR_W-1:0] reload,
  output logic      [TMR_W-1:0] cnt,
  output logic                  ovf,
  output logic                  upd
);
  logic [PRESC_W-1:0] presc_r;
  logic               presc_tick;
  logic               tick;
  logic               wrap;

  // ------------------------------------------------------------
  // clock source selection
  // ------------------------------------------------------------
  // >= keeps the prescaler from running away when sel shrinks mid-count
  assign presc_tick = (presc_r >= dcca_presc_last(sel));
  assign tick = run & ((src == DCCA_SRC_PRESC)  ? presc_tick :
                       (src == DCCA_SRC_CONCAT) ? concat_ovf :
                       (src == DCCA_SRC_EXT)    ? (EXT_OK & ext_rise) : 1'b0);
  assign wrap = tick & (cnt == {TMR_W{1'b1}});

  // prescaler free-runs while the timer is enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_r <= '0;
    end else begin
      presc_r <= (!run || presc_tick) ? '0 : presc_r + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // counter, software write wins over a tick
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
      ovf <= 1'b0;
      upd <= 1'b0;
    end else begin
      ovf <= wrap & ~wr;
      upd <= tick | wr;
      if (wr) begin
        cnt <= wdata;
      end else if (wrap) begin
        cnt <= reload;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : dcca_timer
`default_nettype wire

//--- verilog/dcca_channel.sv
/*
  One dual-purpose capture/compare channel register with its pin logic.
  Assumes pin_lvl is already synchronised and the timer signals come from
  the timer this channel is allocated to.
*/
`timescale 1ns/1ps
`default_nettype none
module dcca_channel import dcca_pkg::*; #(
  parameter bit OUT_OK = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [2:0]       mode,
  input  wire logic [1:0]       edge_sel,
  input  wire logic             pin_lvl,
  input  wire logic [TMR_W-1:0] tmr_cnt,
  input  wire logic             tmr_upd,
  input  wire logic             tmr_ovf,
  input  wire logic             partner_hit,
  input  wire logic             wr,
  input  wire logic [TMR_W-1:0] wdata,
  output logic      [TMR_W-1:0] val,
  output logic                  hit,
  output logic                  evt,
  output logic                  pin_q,
  output logic                  drive
);
  logic pin_d_r;
  logic done_r;
  logic cap;
  logic is_cmp;
  logic once;

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  assign cap    = (mode == DCCA_CAPTURE) &
                  ((edge_sel[0] & pin_lvl & ~pin_d_r) | (edge_sel[1] & ~pin_lvl & pin_d_r));
  assign is_cmp = (mode >= DCCA_CMP0) & (mode <= DCCA_DOUBLE);
  assign once   = (mode == DCCA_CMP2) | (mode == DCCA_CMP3);
  // an overflow in the same cycle opens the new period already
  assign hit    = is_cmp & tmr_upd & (tmr_cnt == val) & ~(once & done_r & ~tmr_ovf);
  assign evt    = cap | hit;
  assign drive  = OUT_OK & ((mode == DCCA_CMP1) | (mode == DCCA_CMP3) | (mode == DCCA_DOUBLE));

  // ------------------------------------------------------------
  // register, period latch and pin state
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      val     <= '0;
      pin_d_r <= 1'b0;
      done_r  <= 1'b0;
      pin_q   <= 1'b0;
    end else begin
      pin_d_r <= pin_lvl;
      // capture beats a software write in the same cycle
      val     <= cap ? tmr_cnt : (wr ? wdata : val);
      done_r  <= (hit & once) ? 1'b1 : (tmr_ovf ? 1'b0 : done_r);
      case (mode)
        DCCA_CMP1:   pin_q <= pin_q ^ hit;
        DCCA_CMP3:   pin_q <= hit ? 1'b1 : (tmr_ovf ? 1'b0 : pin_q);
        DCCA_DOUBLE: pin_q <= pin_q ^ (hit | partner_hit);
        default:     pin_q <= pin_q;
      endcase
    end
  end
endmodule : dcca_channel
`default_nettype wire

//--- dv/dcca_monitor.sv
/* checker on the ports of dcca_top.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dcca_monitor import dcca_pkg::*; (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [DATA_W-1:0]  reg_rdata,
  input wire logic [NUM_CH-1:0]  cc_pin_out,
  input wire logic [NUM_CH-1:0]  cc_pin_oe_n,
  input wire logic [NUM_CH-1:0]  cc_irq,
  input wire logic [NUM_TMR-1:0] timer_irq
);
  // writes seen in the last four cycles, covers the register lag
  logic [3:0] wr_hist_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      wr_hist_r <= 4'h0;
    else
      wr_hist_r <= {wr_hist_r[2:0], reg_wr};
  end
  // requests only drop and drives only start after a software write, never on their own
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  in_only_oe_a: assert property (cc_pin_oe_n[27:24] == 4'hf) else $error("input-only pin enabled");
  in_only_out_a: assert property (cc_pin_out[27:24] == 4'h0) else $error("input-only pin level");
  undriven_low_a: assert property ((cc_pin_out & cc_pin_oe_n) == 32'h0) else $error("undriven pin level");
  rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("data outside slot");
  rd_width_a: assert property (reg_rdata[31:18] == 14'h0) else $error("read data too wide");
  ch_irq_hold_a: assert property (|($past(cc_irq) & ~cc_irq) |-> |wr_hist_r[3:1])
    else $error("channel request dropped");
  tmr_irq_hold_a: assert property (|($past(timer_irq) & ~timer_irq) |-> |wr_hist_r[3:1])
    else $error("timer request dropped");
  drive_start_a: assert property (|($past(cc_pin_oe_n) & ~cc_pin_oe_n) |-> |wr_hist_r)
    else $error("drive without mode write");
endmodule : dcca_monitor
bind dcca_top dcca_monitor i_mon (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n), .cc_irq(cc_irq),
  .timer_irq(timer_irq));
`default_nettype wire

//--- dv/dcca_pins_model.sv
/* far side: port pins and the concatenation timer overflow.
   assumes the bench sets external pin levels and overflow requests. */
`timescale 1ns/1ps
`default_nettype none
module dcca_pins_model import dcca_pkg::*; (
  input  wire logic              clk,
  input  wire logic [NUM_CH-1:0] drv,
  input  wire logic [NUM_CH-1:0] cc_pin_out,
  input  wire logic [NUM_CH-1:0] cc_pin_oe_n,
  input  wire logic              ovf_req,
  output logic      [NUM_CH-1:0] cc_pin_in,
  output logic                   concat_ovf
);
  logic req_q = 1'b0;
  initial concat_ovf = 1'b0;
  // device level wins where it drives, else the outside level
  assign cc_pin_in = (cc_pin_out & ~cc_pin_oe_n) | (drv & cc_pin_oe_n);
  // one-cycle overflow pulse per request rise, as the timer emits
  always @(posedge clk) begin
    req_q      <= ovf_req;
    concat_ovf <= ovf_req & ~req_q;
  end
endmodule : dcca_pins_model
`default_nettype wire

//--- dv/tb_dual_capture_compare_array.sv
/* bench for dcca_top: register tasks, read results via a queue.
   assumes dcca_pins_model as far side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_capture_compare_array import dcca_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ovf_req = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 7'h00, u;
  logic [DATA_W-1:0] reg_rdata, reg_wdata = 32'h0, rnd = 32'd51878, rq[$];
  logic [NUM_CH-1:0] drv = 32'h0, cc_pin_in, cc_pin_out, cc_pin_oe_n, cc_irq;
  logic [NUM_UNITS-1:0] ext_count_in = 2'h0;
  logic [NUM_TMR-1:0] timer_irq;
  logic concat_ovf;
  logic [6:0] ra[6] = '{7'h24, 7'h10, 7'h22, 7'h26, 7'h28, 7'h67};
  int miscompares = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  dcca_top i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out),
    .cc_pin_oe_n(cc_pin_oe_n), .ext_count_in(ext_count_in), .concat_ovf(concat_ovf), .cc_irq(cc_irq),
    .timer_irq(timer_irq));
  dcca_pins_model i_pins (.clk(clk), .drv(drv), .cc_pin_out(cc_pin_out), .cc_pin_oe_n(cc_pin_oe_n),
    .ovf_req(ovf_req), .cc_pin_in(cc_pin_in), .concat_ovf(concat_ovf));
  function automatic logic [31:0] xs(input logic [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one idle cycle after each strobe keeps every strobe one cycle long
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d)
      chk(reg_rdata, rq.pop_front());
    rd_d <= reg_rd;
  end
  // longest path is the prescaler sweep, about 7200 cycles
  initial begin
    #100us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rd(ra[i], 32'h0);
    // each code: read half way between tick three and four
    for (int s = 0; s < 8; s++) begin
      rnd = xs(rnd);
      u = {rnd[0], 6'h0};
      wr(u | 7'h20, 32'h0);
      wr(u | 7'h24, 32'h20 | 32'(s));
      repeat ((28 << s) - 2) @(posedge clk);
      rd(u | 7'h20, 32'h3);
      wr(u | 7'h24, 32'h0);
    end
    // short period on timer 1 with a mode 3 channel on it
    wr(7'h23, 32'hfffd);
    wr(7'h21, 32'hfffd);
    wr(7'h06, 32'hfffe);
    wr(7'h16, 32'h25);
    wr(7'h27, 32'h20040);
    wr(7'h25, 32'h20);
    repeat (26) @(posedge clk);
    chk({timer_irq[1], cc_irq[6], cc_pin_out[6]}, 32'h6);
    wr(7'h25, 32'h0);
    rd(7'h21, 32'hfffd);
    rd(7'h26, 32'h20040);
    wr(7'h26, 32'h20040);
    repeat (3) @(posedge clk);
    chk(32'(timer_irq), 32'h0);
    chk(cc_irq, 32'h0);
    // capture on rise then fall for each edge choice
    wr(7'h27, 32'h4);
    for (int e = 1; e < 4; e++) begin
      wr(7'h02, 32'h0);
      wr(7'h12, 32'h1 | 32'(e << 3));
      wr(7'h20, 32'ha00);
      drv[2] <= 1'b1;
      repeat (6) @(posedge clk);
      rd(7'h02, e[0] ? 32'ha00 : 32'h0);
      wr(7'h20, 32'hb00);
      drv[2] <= 1'b0;
      repeat (6) @(posedge clk);
      rd(7'h02, e[1] ? 32'hb00 : 32'ha00);
    end
    chk(cc_irq, 32'h4);
    // four compare modes on unit 2, matched twice by count writes
    for (int m = 0; m < 4; m++) begin
      wr(7'h40 + 7'(m), 32'h100);
      wr(7'h50 + 7'(m), 32'(m + 2));
    end
    wr(7'h67, 32'hf);
    wr(7'h60, 32'h100);
    repeat (3) @(posedge clk);
    chk({cc_irq[19:16], cc_pin_oe_n[19:16], cc_pin_out[19:16]}, 32'hf5a);
    wr(7'h66, 32'hf);
    wr(7'h60, 32'h100);
    repeat (3) @(posedge clk);
    chk({cc_irq[19:16], cc_pin_oe_n[19:16], cc_pin_out[19:16]}, 32'h358);
    // double mode: channel 1 pin toggled by its partner too
    wr(7'h01, 32'h100);
    wr(7'h09, 32'h200);
    wr(7'h11, 32'h6);
    wr(7'h19, 32'h2);
    wr(7'h20, 32'h200);
    repeat (3) @(posedge clk);
    chk({cc_pin_oe_n[1], cc_pin_out[1]}, 32'h1);
    wr(7'h20, 32'h100);
    repeat (3) @(posedge clk);
    chk({cc_pin_oe_n[1], cc_pin_out[1]}, 32'h0);
    // external count on unit 1 and concatenation overflow on unit 2
    wr(7'h20, 32'h0);
    wr(7'h24, 32'h30);
    wr(7'h61, 32'h0);
    wr(7'h65, 32'h28);
    repeat (5) begin
      ext_count_in[0] <= 1'b1;
      ovf_req <= 1'b1;
      repeat (4) @(posedge clk);
      ext_count_in[0] <= 1'b0;
      ovf_req <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd(7'h20, 32'h5);
    rd(7'h61, 32'h5);
    repeat (2) @(posedge clk);
    tally_and_finish;
  end
endmodule : tb_dual_capture_compare_array
`default_nettype wire
